/* hw/lalr_defs.vh */
// Purpose: constants for the lane alarm latch register bank
// Assumes: register index = printed offset, byte address = 4 * index
// Notes:   definitions only
`ifndef LALR_DEFS_VH
`define LALR_DEFS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define LALR_IDX_FAULT_STAT   16'hb1a0
`define LALR_IDX_LATCH1       16'hb1b0
`define LALR_IDX_LATCH2       16'hb1c0
`define LALR_IDX_FAULT_LATCH  16'hb1d0
`define LALR_IDX_ENABLE1      16'hb1e0
`define LALR_IDX_IRQ_STAT     16'hb1f0
`define LALR_IDX_IRQ_MASK     16'hb1f1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define LALR_RST_LATCH        16'h0000
`define LALR_RST_ENABLE1      16'hffff
`define LALR_RST_IRQ_STAT     16'h0000
`define LALR_RST_IRQ_MASK     16'h0000

// ----------------------------------------------------------------
// first latch word field positions (bias low alarm bit, then lsb of each group of four)
// ----------------------------------------------------------------
`define LALR_BIAS_LO_ALM_BIT  12
`define LALR_TXPWR_LSB        8
`define LALR_LTEMP_LSB        4
`define LALR_RXPWR_LSB        0
`define LALR_LATCH1_MASK      16'hffff

// ----------------------------------------------------------------
// second latch word and fault latch word
// ----------------------------------------------------------------
`define LALR_MODBIAS_LSB      0
`define LALR_LATCH2_MASK      16'h000f
`define LALR_TEC_FLT_BIT      15
`define LALR_WL_UNLOCK_BIT    14
`define LALR_TX_LOSS_BIT      7
`define LALR_RECEIVE_SIGNAL_LOSS_BIT       4
`define LALR_RX_TEC_BIT       1
`define LALR_FAULT_MASK_BASE  16'hc090
`define LALR_FAULT_MASK_RXTEC 16'h0002

`endif

/* hw/lalr_top.v */
// Purpose: per-lane sticky alarm, warning and fault latch words over APB
// Assumes: live status inputs synchronous to pclk; zero-wait APB slave
// Notes:   lanes at or above num_lanes read zero and never latch
//          a read clears only the bits it returned
//          a set and a clear in one cycle leave the bit set
//
// Overview of operation
// - each latch bit is read-only, sets while its source is raised, holds, and clears on read.
// - first latch word: laser bias low alarm at bit 12, transmit power alarms at bits 11 to 8.
// - first latch word: laser temperature at bits 7 to 4, receive power at bits 3 to 0.
// - a second latch word per lane sits in an array at b1c0 and resets to zero.
// - second latch word: modulator bias at bits 3 to 0, bits 15 to 4 read zero.
// - a fault latch word per lane sits in an array at b1d0 and resets to zero.
// - fault latch: cooler fault 15, unlocked 14, transmit loss 7, receive loss 4, rest reserved.
// - an optional receive cooler fault latch at fault bit 1 behaves like the others.
// - each array holds up to sixteen words, one per lane, lane count set by the build.
// - each latch bit is fed by its matching live per-lane status bit, high while asserted.
// - a per-lane enable word at b1e0, reset ffff, gates interrupt events from first-word latches; latching and reads are not gated.
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "lalr_defs.vh"

module lalr_top #(
    parameter [4:0] NUM_LANES = 5'd16,
    parameter       RX_TEC_EN = 1
) (
    // clock and reset
    input  wire         pclk,
    input  wire         presetn,
    // apb slave
    input  wire         psel,
    input  wire         penable,
    input  wire         pwrite,
    input  wire [31:0]  paddr,
    input  wire [31:0]  pwdata,
    input  wire [3:0]   pstrb,
    output wire [31:0]  prdata,
    output wire         pready,
    output wire         pslverr,
    // live per-lane status, lane n in bits [16n+15:16n] or [4n+3:4n]
    input  wire [255:0] lane_pwr_temp_bias_stat,
    input  wire [63:0]  lane_mod_bias_stat,
    input  wire [255:0] lane_fault_stat,
    // interrupt
    output wire         irq
);

    // ----------------------------------------------------------------
    // address decode helpers
    // ----------------------------------------------------------------
    function in_array;
        input [31:0] a;
        input [15:0] base;
        begin
            in_array = (a[31:18] == 14'h0000) && (a[17:6] == base[15:4]);
        end
    endfunction

    function is_reg;
        input [31:0] a;
        input [15:0] base;
        begin
            is_reg = (a[31:2] == {14'h0000, base});
        end
    endfunction

    // ----------------------------------------------------------------
    // latch, strobe and lane helpers
    // ----------------------------------------------------------------
    function [15:0] latch_next;
        input [15:0] q;
        input [15:0] clr;
        input [15:0] set_bits;
        begin
            latch_next = (q & ~clr) | set_bits;
        end
    endfunction

    function [15:0] strb_merge;
        input [15:0] q;
        input [31:0] wd;
        input [3:0]  strb;
        begin
            strb_merge = q;
            if (strb[0]) begin
                strb_merge[7:0] = wd[7:0];
            end
            if (strb[1]) begin
                strb_merge[15:8] = wd[15:8];
            end
        end
    endfunction

    function [15:0] lane_gate;
        input [15:0] w;
        input        en;
        begin
            lane_gate = w & {16{en}};
        end
    endfunction

    function [15:0] clr_pick;
        input        sel;
        input        hit;
        input [15:0] clr;
        begin
            clr_pick = (sel && hit) ? clr : 16'h0000;
        end
    endfunction

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    reg  [15:0] lat1_ff [0:15];
    reg  [15:0] lat2_ff [0:15];
    reg  [15:0] flt_ff  [0:15];
    reg  [15:0] en1_ff  [0:15];
    reg  [15:0] irq_stat_ff;
    reg  [15:0] irq_mask_ff;
    reg  [31:0] prdata_ff;

    wire [15:0] lane_en;
    wire [15:0] fault_mask;
    wire [3:0]  lane;
    wire        lane_ok;
    wire        setup_ph;
    wire        acc_rd;
    wire        acc_wr;

    reg  [15:0] rd_word;
    reg         rd_err;
    reg         sel_lat1;
    reg         sel_lat2;
    reg         sel_flt;
    reg         sel_en1;
    reg         sel_istat;
    reg         sel_imask;
    reg  [15:0] evt;
    reg  [15:0] set1;
    reg  [15:0] set2;
    reg  [15:0] setf;
    reg  [15:0] nxt_lat1 [0:15];
    reg  [15:0] nxt_lat2 [0:15];
    reg  [15:0] nxt_flt  [0:15];
    reg  [15:0] nxt_en1  [0:15];
    reg  [15:0] nxt_irq_stat;
    reg  [15:0] nxt_irq_mask;
    reg  [31:0] nxt_prdata;
    wire [15:0] lane_hit;
    wire [15:0] rd_clr;
    wire [15:0] irq_pend;

    integer i;
    integer j;
    integer k;
    integer m;

    // ----------------------------------------------------------------
    // lane count, lane select and phase decode
    // ----------------------------------------------------------------

    assign lane_en    = ~(16'hffff << NUM_LANES);
    assign fault_mask = (RX_TEC_EN != 0) ?
                        (`LALR_FAULT_MASK_BASE | `LALR_FAULT_MASK_RXTEC) :
                        `LALR_FAULT_MASK_BASE;
    assign lane       = paddr[5:2];
    assign lane_ok    = lane_en[lane];
    assign setup_ph   = psel & ~penable;
    assign acc_rd     = psel & penable & ~pwrite;
    assign acc_wr     = psel & penable & pwrite;
    assign lane_hit   = 16'h0001 << lane;
    assign rd_clr     = acc_rd ? prdata_ff[15:0] : 16'h0000;

    // ----------------------------------------------------------------
    // read mux and decode
    // ----------------------------------------------------------------
    always @* begin
        rd_word   = 16'h0000;
        rd_err    = 1'b0;
        sel_lat1  = 1'b0;
        sel_lat2  = 1'b0;
        sel_flt   = 1'b0;
        sel_en1   = 1'b0;
        sel_istat = 1'b0;
        sel_imask = 1'b0;
        if (in_array(paddr, `LALR_IDX_FAULT_STAT)) begin
            if (lane_ok) begin
                rd_word = lane_fault_stat[lane*16 +: 16] & fault_mask;
            end
        end else if (in_array(paddr, `LALR_IDX_LATCH1)) begin
            sel_lat1 = lane_ok;
            if (lane_ok) begin
                rd_word = lat1_ff[lane];
            end
        end else if (in_array(paddr, `LALR_IDX_LATCH2)) begin
            sel_lat2 = lane_ok;
            if (lane_ok) begin
                rd_word = lat2_ff[lane];
            end
        end else if (in_array(paddr, `LALR_IDX_FAULT_LATCH)) begin
            sel_flt = lane_ok;
            if (lane_ok) begin
                rd_word = flt_ff[lane];
            end
        end else if (in_array(paddr, `LALR_IDX_ENABLE1)) begin
            sel_en1 = lane_ok;
            if (lane_ok) begin
                rd_word = en1_ff[lane];
            end
        end else if (is_reg(paddr, `LALR_IDX_IRQ_STAT)) begin
            sel_istat = 1'b1;
            rd_word   = irq_stat_ff;
        end else if (is_reg(paddr, `LALR_IDX_IRQ_MASK)) begin
            sel_imask = 1'b1;
            rd_word   = irq_mask_ff;
        end else begin
            rd_err = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // set terms and interrupt events
    // ----------------------------------------------------------------
    always @* begin
        evt  = 16'h0000;
        set1 = 16'h0000;
        set2 = 16'h0000;
        setf = 16'h0000;
        for (i = 0; i < 16; i = i + 1) begin
            // live bit high sets the latch, lane gated by count
            set1 = lane_gate(lane_pwr_temp_bias_stat[i*16 +: 16] & `LALR_LATCH1_MASK,
                             lane_en[i]);
            set2 = lane_gate({12'h000, lane_mod_bias_stat[i*4 +: 4]} & `LALR_LATCH2_MASK,
                             lane_en[i]);
            setf = lane_gate(lane_fault_stat[i*16 +: 16] & fault_mask,
                             lane_en[i]);
            evt[i] = (|(set1 & ~lat1_ff[i] & en1_ff[i]))
                   | (|(set2 & ~lat2_ff[i]))
                   | (|(setf & ~flt_ff[i]));
        end
    end

    // ----------------------------------------------------------------
    // next latch words and enables
    // ----------------------------------------------------------------
    always @* begin
        for (j = 0; j < 16; j = j + 1) begin
            // clear only the bits returned; a set in the same cycle wins
            nxt_lat1[j] = latch_next(lat1_ff[j], clr_pick(sel_lat1, lane_hit[j], rd_clr),
                lane_gate(lane_pwr_temp_bias_stat[j*16 +: 16] & `LALR_LATCH1_MASK,
                          lane_en[j]));
            nxt_lat2[j] = latch_next(lat2_ff[j], clr_pick(sel_lat2, lane_hit[j], rd_clr),
                lane_gate({12'h000, lane_mod_bias_stat[j*4 +: 4]} & `LALR_LATCH2_MASK,
                          lane_en[j]));
            nxt_flt[j]  = latch_next(flt_ff[j], clr_pick(sel_flt, lane_hit[j], rd_clr),
                lane_gate(lane_fault_stat[j*16 +: 16] & fault_mask,
                          lane_en[j]));
            nxt_en1[j]  = en1_ff[j];
            if (acc_wr && sel_en1 && lane_hit[j]) begin
                nxt_en1[j] = strb_merge(en1_ff[j], pwdata, pstrb);
            end
        end
    end

    // ----------------------------------------------------------------
    // next interrupt status and mask
    // ----------------------------------------------------------------
    always @* begin
        nxt_irq_stat = latch_next(irq_stat_ff, clr_pick(sel_istat, 1'b1, rd_clr), evt);
        nxt_irq_mask = irq_mask_ff;
        if (acc_wr && sel_imask) begin
            nxt_irq_mask = strb_merge(irq_mask_ff, pwdata, pstrb);
        end
    end

    // ----------------------------------------------------------------
    // latch words
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (k = 0; k < 16; k = k + 1) begin
                lat1_ff[k] <= `LALR_RST_LATCH;
                lat2_ff[k] <= `LALR_RST_LATCH;
                flt_ff[k]  <= `LALR_RST_LATCH;
            end
        end else begin
            for (k = 0; k < 16; k = k + 1) begin
                lat1_ff[k] <= nxt_lat1[k];
                lat2_ff[k] <= nxt_lat2[k];
                flt_ff[k]  <= nxt_flt[k];
            end
        end
    end

    // ----------------------------------------------------------------
    // per-lane enable words
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (m = 0; m < 16; m = m + 1) begin
                en1_ff[m] <= `LALR_RST_ENABLE1;
            end
        end else begin
            for (m = 0; m < 16; m = m + 1) begin
                en1_ff[m] <= nxt_en1[m];
            end
        end
    end

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= `LALR_RST_IRQ_STAT;
            irq_mask_ff <= `LALR_RST_IRQ_MASK;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            irq_mask_ff <= nxt_irq_mask;
        end
    end

    // ----------------------------------------------------------------
    // read data captured in the setup cycle
    // ----------------------------------------------------------------
    always @* begin
        nxt_prdata = prdata_ff;
        if (setup_ph) begin
            nxt_prdata = {16'h0000, rd_word};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else begin
            prdata_ff <= nxt_prdata;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata  = prdata_ff;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & rd_err;
    assign irq_pend = irq_stat_ff & irq_mask_ff;
    assign irq     = |irq_pend;

endmodule // lalr_top

/* test/lalr_top_assertions.sv */
// Purpose: port checks for the lane latch bank
// Assumes: bound to lalr_top
// Notes:   checks read data, ready in every cycle, and no error outside access or on latch arrays
`timescale 1ns/1ps
`include "lalr_defs.vh"
module lalr_top_assertions #(
    parameter [4:0] NUM_LANES = 5'd16
) (
    // clock and reset
    input wire         pclk,
    input wire         presetn,
    // apb and status
    input wire         psel,
    input wire         penable,
    input wire         pwrite,
    input wire [31:0]  paddr,
    input wire [31:0]  prdata,
    input wire         pready,
    input wire         pslverr,
    input wire [63:0]  lane_mod_bias_stat
);
    wire [29:0] base  = {paddr[31:6], 4'h0};
    wire        acc   = psel && penable && !pwrite;
    wire        in_l1 = base == {14'h0, `LALR_IDX_LATCH1};
    wire        in_l2 = base == {14'h0, `LALR_IDX_LATCH2};
    wire        in_fl = base == {14'h0, `LALR_IDX_FAULT_LATCH};
    wire        dead  = {1'b0, paddr[5:2]} >= NUM_LANES;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_high: assert property (pready) else $error("pready low");
    a_upper_zero: assert property (acc |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_mod_reserved: assert property (acc && in_l2 |-> prdata[15:4] == 12'h000)
        else $error("modulator word reserved bits set");
    a_fault_reserved: assert property (acc && in_fl |-> (prdata[15:0] & 16'h3f6d) == 16'h0)
        else $error("fault word reserved bits set");
    a_dead_lane: assert property (acc && (in_l1 || in_l2 || in_fl) && dead |-> prdata == 32'h0)
        else $error("absent lane reads nonzero");
    a_held_source: assert property (psel && !penable && !pwrite && in_l2 && paddr[5:2] == 4'h0
        && $past(presetn) && $past(lane_mod_bias_stat[0]) |=> prdata[0])
        else $error("held source not latched");
    a_err_phase: assert property (pslverr |-> psel && penable) else $error("stray error");
    a_arrays_mapped: assert property (psel && penable && (in_l1 || in_l2 || in_fl) |-> !pslverr)
        else $error("latch array refused");
    a_read_stable: assert property (psel && penable |=> $stable(prdata))
        else $error("read data moved in access");
endmodule // lalr_top_assertions
bind lalr_top lalr_top_assertions #(.NUM_LANES(NUM_LANES)) lalr_top_assertions_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lane_mod_bias_stat(lane_mod_bias_stat));

/* test/lalr_host.sv */
// Purpose: apb host model for the latch bank
// Assumes: zero or more wait states
// Notes:   bounded wait on pready
`timescale 1ns/1ps
module lalr_host (
    // clock
    input wire         pclk,
    // apb master
    output reg         psel,
    output reg         penable,
    output reg         pwrite,
    output reg [31:0]  paddr,
    output reg [31:0]  pwdata,
    output reg [3:0]   pstrb,
    input wire [31:0]  prdata,
    input wire         pready,
    input wire         pslverr
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata, pstrb} = 71'h0;
    end
    task xfer(input w, input [15:0] idx, input [31:0] wd, output [31:0] rd,
              output e, output ok);
        integer n;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= {14'h0, idx, 2'b00};
            pwdata <= wd;
            pstrb <= 4'hf;
            @(posedge pclk);
            penable <= 1'b1;
            ok = 1'b0;
            for (n = 0; n < 16 && !ok; n = n + 1) begin
                @(posedge pclk);
                ok = (pready === 1'b1);
            end
            rd = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
endmodule // lalr_host

/* test/lalr_top_test.sv */
// Purpose: self-checking bench for the latch bank
// Assumes: four lanes built
// Notes:   row table then hand cases
`timescale 1ns/1ps
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin bad_count++; \
    $display("CHECK FAILED at %0t: got %h want %h", $time, g, x); end end
module lalr_top_test;
    logic        pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr, irq, e;
    logic [31:0] paddr, pwdata, prdata, r;
    logic [3:0]  pstrb;
    logic [255:0] pwr = 0, flt = 0;
    logic [63:0] mods = 0;
    logic [47:0] rows [8];
    int          checks = 0, bad_count = 0;
    always #5 pclk = ~pclk;
    lalr_top #(.NUM_LANES(5'd4), .RX_TEC_EN(1)) lalr_top_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .lane_pwr_temp_bias_stat(pwr), .lane_mod_bias_stat(mods), .lane_fault_stat(flt),
        .irq(irq));
    lalr_host lalr_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    task tally_and_finish;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task apb(input w, input [15:0] idx, input [31:0] wd);
        logic ok;
        lalr_host_i.xfer(w, idx, wd, r, e, ok);
        if (!ok) begin
            bad_count++;
            tally_and_finish;
        end
    endtask
    task put(input [15:0] idx, input [15:0] pat);
        @(posedge pclk);
        case (idx[15:4])
            12'hb1b: pwr[16*idx[3:0] +: 16] <= pat;
            12'hb1c: mods[4*idx[3:0] +: 4] <= pat[3:0];
            default: flt[16*idx[3:0] +: 16] <= pat;
        endcase
    endtask
    initial begin
        rows = '{{16'hb1b0, 16'h1000, 16'h1000}, {16'hb1b1, 16'h0f00, 16'h0f00},
                 {16'hb1b2, 16'h00f0, 16'h00f0}, {16'hb1b3, 16'h000f, 16'h000f},
                 {16'hb1c1, 16'hffff, 16'h000f}, {16'hb1d2, 16'hffff, 16'hc092},
                 {16'hb1d3, 16'h0080, 16'h0080}, {16'hb1b5, 16'hffff, 16'h0000}};
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            put(rows[i][47:32], rows[i][31:16]);
            put(rows[i][47:32], 16'h0);
            apb(0, rows[i][47:32], 0);
            `CHK(r, {16'h0, rows[i][15:0]})
            apb(0, rows[i][47:32], 0);
            `CHK(r, 32'h0)
        end
        apb(0, 16'hb1f0, 0);
        `CHK(r, 32'h0000000f)
        apb(0, 16'hb1c0, 0);
        `CHK(r, 32'h0)
        apb(0, 16'hb1d0, 0);
        `CHK(r, 32'h0)
        apb(0, 16'hb1e0, 0);
        `CHK(r, 32'h0000ffff)
        apb(1, 16'hb1d0, 32'hffff);
        apb(0, 16'hb1d0, 0);
        `CHK(r, 32'h0)
        apb(0, 16'hb1bf, 0);
        `CHK(e, 1'b0)
        apb(0, 16'h0100, 0);
        `CHK(e, 1'b1)
        apb(1, 16'hb1f1, 32'h2);
        `CHK(irq, 1'b0)
        put(16'hb1d1, 16'h8000);
        put(16'hb1d1, 16'h0);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(0, 16'hb1f0, 0);
        `CHK(r, 32'h2)
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(1, 16'hb1e1, 32'h0);
        put(16'hb1b1, 16'h0100);
        put(16'hb1b1, 16'h0);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(0, 16'hb1b1, 0);
        `CHK(r, 32'h0100)
        put(16'hb1c0, 16'h5);
        apb(0, 16'hb1c0, 0);
        apb(0, 16'hb1c0, 0);
        `CHK(r, 32'h5)
        put(16'hb1c0, 16'h0);
        apb(0, 16'hb1c0, 0);
        apb(0, 16'hb1c0, 0);
        `CHK(r, 32'h0)
        put(16'hb1d0, 16'h0010);
        put(16'hb1d0, 16'h0);
        apb(1, 16'hb1f1, 32'h3);
        @(posedge pclk);
        `CHK(irq, 1'b1)
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
        presetn <= 1'b1;
        apb(0, 16'hb1d0, 0);
        `CHK(r, 32'h0)
        apb(0, 16'hb1e1, 0);
        `CHK(r, 32'h0000ffff)
        apb(0, 16'hb1f1, 0);
        `CHK(r, 32'h0)
        tally_and_finish;
    end
endmodule // lalr_top_test
